/* rtl/sac_pkg.sv */
// Shared constants and types of the sampling converter port
`default_nettype none
package sac_pkg;

  // Clock and conversion timing
  localparam int SAC_CLK_PERIOD_NS = 100;
  localparam int SAC_CONV_TIME_NS = 2700;
  localparam int SAC_CYCLE_TIME_NS = 3000;
  localparam int SAC_START_LOW_NS = 40;
  // Longest time, so round down
  localparam int SAC_CONV_CYCLES = SAC_CONV_TIME_NS / SAC_CLK_PERIOD_NS;
  localparam int SAC_CYCLE_CYCLES = SAC_CYCLE_TIME_NS / SAC_CLK_PERIOD_NS;
  // Least time, so round up, at least one cycle
  localparam int SAC_START_LOW_CYCLES =
    (SAC_START_LOW_NS + SAC_CLK_PERIOD_NS - 1) / SAC_CLK_PERIOD_NS;

  // Result width and byte layout
  localparam int SAC_RES_W = 12;
  localparam int SAC_UPPER_LSB = 8;
  localparam int SAC_NIB_W = 4;
  localparam logic [SAC_RES_W-1:0] SAC_RESULT_RST = 12'h000;

  // Control pins from the host
  typedef struct packed {
    logic cs_b;
    logic read_convert;
    logic upper_byte_select;
  } sac_ctrl_t;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_CONV = 2'b01
  } sac_state_t;

endpackage
`default_nettype wire

/* rtl/sac_port.sv */
// Host-facing control and three-state output logic of the converter
`timescale 1ns/10ps
`default_nettype none
module sac_port
  import sac_pkg::*;
#(
  parameter int RES_W = SAC_RES_W,
  parameter int CONV_CYCLES = SAC_CONV_CYCLES
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire sac_ctrl_t ctrl,
  input wire logic [RES_W-1:0] sample_code,
  output logic busy_b,
  output logic [RES_W-1:0] data_out,
  output logic data_oe_b
);

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CONV_CYCLES - 1);

  // The engine needs its twelve trials plus hold and latch
  if (CONV_CYCLES < RES_W + 3 || CONV_CYCLES > SAC_CONV_CYCLES ||
      RES_W != SAC_RES_W)
  begin : g_bad_params
    $error("sac_port: parameters outside what the logic can serve");
  end

  // Output byte steering for word and upper byte reads
  function automatic logic [RES_W-1:0] sac_place(
    input logic [RES_W-1:0] res,
    input logic upper
  );
    logic [RES_W-1:0] word;
    word = res;
    if (upper)
    begin
      word[SAC_UPPER_LSB-1:SAC_NIB_W] = '0;
      word[SAC_NIB_W-1:0] = res[RES_W-1:SAC_UPPER_LSB];
    end
    return word;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Start detection

  logic rc_q;
  logic start;
  sac_state_t state;
  logic [CNT_W-1:0] conv_cnt;
  logic core_done;
  logic [RES_W-1:0] core_result;
  logic [RES_W-1:0] result_q;

  // Previous read_convert level for the falling edge
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      rc_q <= 1'b1;
    else
      rc_q <= ctrl.read_convert;
  end

  // Gated fall; in conversion all control edges are dropped
  assign start = rc_q && !ctrl.read_convert && !ctrl.cs_b
    && !ctrl.upper_byte_select && state == SAC_IDLE;

  ////////////////////////////////////////////////////////////////////////
  // Conversion timing

  // Fixed-length window so busy time never depends on the code
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      state <= SAC_IDLE;
      conv_cnt <= '0;
    end
    else
    begin
      unique case (state)
        SAC_IDLE:
        begin
          conv_cnt <= '0;
          if (start)
            state <= SAC_CONV;
        end
        SAC_CONV:
        begin
          conv_cnt <= conv_cnt + CNT_W'(1);
          if (conv_cnt == CNT_LAST)
            state <= SAC_IDLE;
        end
      endcase
    end
  end

  // Busy output follows the state, low from start to release
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      busy_b <= 1'b1;
    else if (start)
      busy_b <= 1'b0;
    else if (state == SAC_CONV && conv_cnt == CNT_LAST)
      busy_b <= 1'b1;
  end

  sac_sar_core #(
    .RES_W(RES_W)
  ) u_core (
    .clk(clk),
    .rst_b(rst_b),
    .start(start),
    .sample_code(sample_code),
    .done(core_done),
    .result(core_result)
  );

  // Output register; latched well before busy_b rises
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      result_q <= SAC_RESULT_RST;
    else if (core_done)
      result_q <= core_result;
  end

  ////////////////////////////////////////////////////////////////////////
  // Output drivers

  // Steered word; last result stays for read mode
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      data_out <= SAC_RESULT_RST;
    else
      data_out <= sac_place(result_q, ctrl.upper_byte_select);
  end

  // Enable one cycle behind the pins; cs_b high always disables
  always_ff @(posedge clk)
  begin
    if (!rst_b)
      data_oe_b <= 1'b1;
    else
      data_oe_b <= ctrl.cs_b || !ctrl.read_convert
        || state != SAC_IDLE || start;
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic [CNT_W:0] low_cnt;
  logic done_seen;

  // Helper: busy low length and latch seen in this conversion
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      low_cnt <= '0;
      done_seen <= 1'b0;
    end
    else if (busy_b)
    begin
      low_cnt <= '0;
      done_seen <= 1'b0;
    end
    else
    begin
      low_cnt <= low_cnt + (CNT_W+1)'(1);
      if (core_done)
        done_seen <= 1'b1;
    end
  end

  AST_START_GATED: assert property (
    $fell(busy_b) |-> $past(rc_q && !ctrl.read_convert && !ctrl.cs_b
      && !ctrl.upper_byte_select))
    else $error("busy fell without a legal start");

  AST_START_TAKEN: assert property (
    (busy_b && rc_q && !ctrl.read_convert && !ctrl.cs_b
      && !ctrl.upper_byte_select) |=> !busy_b)
    else $error("legal start not taken");

  AST_BUSY_LENGTH: assert property (
    $rose(busy_b) |-> $past(low_cnt) == (CNT_W+1)'(CONV_CYCLES - 1))
    else $error("busy low time differs from conversion time");

  AST_THROUGHPUT: assert property (
    !busy_b |-> low_cnt < (CNT_W+1)'(SAC_CYCLE_CYCLES))
    else $error("conversion overran the cycle time");

  AST_DATA_AT_RISE: assert property (
    $rose(busy_b) |-> $past(done_seen) && result_q == core_result)
    else $error("busy rose before the result latched");

  AST_HIZ_DESELECT: assert property (
    $past(ctrl.cs_b) |-> data_oe_b)
    else $error("outputs driven while deselected");

  AST_ENABLE_TERMS: assert property (
    !data_oe_b |-> $past(ctrl.read_convert && !ctrl.cs_b && busy_b))
    else $error("outputs driven outside read window");

  AST_WORD_MODE: assert property (
    !data_oe_b && $past(!ctrl.upper_byte_select)
      |-> data_out == $past(result_q))
    else $error("word mode output mismatch");

  AST_UPPER_MODE: assert property (
    !data_oe_b && $past(ctrl.upper_byte_select)
      |-> data_out[SAC_UPPER_LSB-1:0]
        == {4'h0, $past(result_q[RES_W-1:SAC_UPPER_LSB])})
    else $error("upper byte output mismatch");

  AST_NO_RESTART: assert property (
    $past(!busy_b) && !busy_b
      |-> !$past(start) && conv_cnt == $past(conv_cnt) + CNT_W'(1))
    else $error("conversion restarted while busy");

  COV_CONVERT: cover property ($rose(busy_b));
  COV_READ_WORD: cover property (!data_oe_b && !ctrl.upper_byte_select);
  COV_READ_UPPER: cover property (!data_oe_b && ctrl.upper_byte_select);
  COV_IGNORED_EDGE: cover property (
    !busy_b && rc_q && !ctrl.read_convert && !ctrl.cs_b);

endmodule // sac_port
`default_nettype wire

/* rtl/sac_sar_core.sv */
// Successive approximation engine: one trial bit per clock
`timescale 1ns/10ps
`default_nettype none
module sac_sar_core
  import sac_pkg::*;
#(
  parameter int RES_W = SAC_RES_W
)
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic start,
  input wire logic [RES_W-1:0] sample_code,
  output logic done,
  output logic [RES_W-1:0] result
);

  logic run;
  logic [RES_W-1:0] held;
  logic [RES_W-1:0] trial_bit;
  logic [RES_W-1:0] code;
  logic [RES_W-1:0] next_code;

  // Reset value and trial walk are sized for the package width
  if (RES_W != SAC_RES_W)
  begin : g_bad_width
    $error("sac_sar_core: RES_W must match the package width");
  end

  // Keep the trial bit when the candidate does not exceed the held level
  always_comb
  begin
    next_code = code;
    if ((code | trial_bit) <= held)
      next_code = code | trial_bit;
  end

  // Hold the sample at the start edge, then walk from MSB to LSB
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      run <= 1'b0;
      held <= '0;
      trial_bit <= '0;
      code <= '0;
    end
    else if (start)
    begin
      run <= 1'b1;
      held <= sample_code;
      trial_bit <= {1'b1, {(RES_W-1){1'b0}}};
      code <= '0;
    end
    else if (run)
    begin
      code <= next_code;
      trial_bit <= trial_bit >> 1;
      if (trial_bit[0])
        run <= 1'b0;
    end
  end

  // Result and one-cycle done after the LSB trial
  always_ff @(posedge clk)
  begin
    if (!rst_b)
    begin
      done <= 1'b0;
      result <= SAC_RESULT_RST;
    end
    else
    begin
      done <= run && trial_bit[0] && !start;
      if (run && trial_bit[0] && !start)
        result <= next_code;
    end
  end

endmodule // sac_sar_core
`default_nettype wire

/* testbench/sac_host_model.sv */
// Host-side model driving the converter control pins
`timescale 1ns/10ps
`default_nettype none
module sac_host_model
  import sac_pkg::*;
(
  input wire logic clk,
  output var sac_ctrl_t ctrl,
  output var logic [SAC_RES_W-1:0] sample_code
);
  realtime last_fall;
  ////////////////////////////////////////////////////////////////////////
  // Idle deselected with read_convert high, so a later fall counts
  initial
  begin
    ctrl = 3'b110;
    sample_code = 12'h000;
    last_fall = -1.0e6;
  end
  // Pins change only after a rising edge
  task automatic set_pins(input logic cs_b, input logic rc,
    input logic ube);
    @(posedge clk);
    ctrl <= {cs_b, rc, ube};
  endtask
  // Start pulse; select and byte lines settle before the fall
  task automatic pulse(input logic cs_b, input logic ube,
    input logic [SAC_RES_W-1:0] code);
    set_pins(cs_b, 1'b1, ube);
    sample_code <= code;
    // Keep starts a full cycle time apart
    while ($realtime - last_fall < SAC_CYCLE_TIME_NS - SAC_CLK_PERIOD_NS)
      @(posedge clk);
    set_pins(cs_b, 1'b0, ube);
    last_fall = $realtime;
    // Low for the minimum start width, in whole cycles
    repeat (SAC_START_LOW_CYCLES - 1)
      @(posedge clk);
    set_pins(cs_b, 1'b1, ube);
  endtask
endmodule // sac_host_model
`default_nettype wire

/* testbench/sampling_adc_parallel_port_bench.sv */
// Self-checking bench for the converter port
`timescale 1ns/10ps
`default_nettype none
module sampling_adc_parallel_port_bench;
  import sac_pkg::*;
  logic clk, rst_b, busy_b, data_oe_b;
  sac_ctrl_t ctrl;
  logic [11:0] sample_code, data_out, got;
  logic [11:0] codes [4] = '{12'hA5C, 12'hFFF, 12'h000, 12'h801};
  int n_fail = 0, compares = 0, cycles = 0, len;
  sac_host_model u_host (.clk(clk), .ctrl(ctrl),
    .sample_code(sample_code));
  sac_port u_dut (.clk(clk), .rst_b(rst_b), .ctrl(ctrl),
    .sample_code(sample_code), .busy_b(busy_b), .data_out(data_out),
    .data_oe_b(data_oe_b));
  ////////////////////////////////////////////////////////////////////////
  // 100 ns clock
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard; the run needs well under a thousand cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_fail++;
      summarize();
    end
  end
  task automatic check(input string what, input logic [11:0] seen,
    input logic [11:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // Let the edge's updates land before looking
  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  // Count busy cycles; drivers must stay off throughout
  task automatic busy_len(inout int n);
    #1;
    while (busy_b === 1'b0 && n < 40)
    begin
      check("oe_busy", 12'(data_oe_b), 12'h001);
      tick();
      n++;
    end
    check("busy_len", 12'(n), 12'(SAC_CONV_CYCLES));
  endtask
  // Outputs are registered, so look one cycle after selecting
  task automatic read_out(input logic ube, output logic [11:0] d);
    u_host.set_pins(1'b0, 1'b1, ube);
    tick();
    d = data_out;
    check("oe_read", 12'(data_oe_b), 12'h000);
  endtask
  task automatic deselect();
    u_host.set_pins(1'b1, 1'b1, 1'b0);
    tick();
    check("oe_desel", 12'(data_oe_b), 12'h001);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_convert(input logic [11:0] code);
    len = 0;
    u_host.pulse(1'b0, 1'b0, code);
    busy_len(len);
    read_out(1'b0, got);
    check("word", got, code);
    read_out(1'b1, got);
    check("upper", 12'(got[7:0]), {8'h00, code[11:8]});
    deselect();
    $display("t_convert %h done", code);
  endtask
  // Falls with select or upper byte high must not start
  task automatic t_refused();
    u_host.pulse(1'b1, 1'b0, 12'h123);
    tick();
    check("busy_cs", 12'(busy_b), 12'h001);
    u_host.pulse(1'b0, 1'b1, 12'h456);
    tick();
    check("busy_ube", 12'(busy_b), 12'h001);
    deselect();
    $display("t_refused done");
  endtask
  // A second fall and deselect in mid conversion change nothing
  task automatic t_ignore();
    u_host.pulse(1'b0, 1'b0, 12'h3C7);
    u_host.set_pins(1'b0, 1'b0, 1'b0);
    u_host.set_pins(1'b1, 1'b1, 1'b1);
    u_host.set_pins(1'b0, 1'b1, 1'b0);
    len = 3;
    busy_len(len);
    read_out(1'b0, got);
    check("ignore", got, 12'h3C7);
    deselect();
    $display("t_ignore done");
  endtask
  // Starts at the full cycle rate, no read between
  task automatic t_b2b();
    len = 0;
    u_host.pulse(1'b0, 1'b0, 12'hA5C);
    busy_len(len);
    len = 0;
    u_host.pulse(1'b0, 1'b0, 12'h5A3);
    busy_len(len);
    read_out(1'b0, got);
    check("b2b", got, 12'h5A3);
    deselect();
    $display("t_b2b done");
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Reset, then the scenarios in turn
  initial
  begin
    rst_b = 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    tick();
    check("rst_busy", 12'(busy_b), 12'h001);
    check("rst_oe", 12'(data_oe_b), 12'h001);
    foreach (codes[i])
      t_convert(codes[i]);
    t_refused();
    t_ignore();
    t_b2b();
    summarize();
  end
endmodule // sampling_adc_parallel_port_bench
`default_nettype wire
